// ==== hdl/psc_consts.svh ====
// Constants of the passive serial configuration loader
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH
`define PSC_LANES_DEF       4
`define PSC_FIFO_DEPTH      4
`define PSC_CLK_MHZ         100
`define PSC_CLKDIV_DEF      8
`define PSC_WAIT_ENH        64
`define PSC_WAIT_OLD        16
`define PSC_INIT_FAM0       136
`define PSC_INIT_FAM1       40
`define PSC_INIT_FAM23      10
`define PSC_RETRY_US        40
`define PSC_RETRY_CYC       (`PSC_RETRY_US * `PSC_CLK_MHZ)
`define PSC_ERR_PULSE       4
`define PSC_RESTART_PULSE   16
`endif

// ==== hdl/psc_pkg.sv ====
// Types of the passive serial configuration loader
package psc_pkg;
  typedef enum logic [2:0] {
    PSC_IDLE, PSC_WAITREL, PSC_SEND, PSC_DONEWAIT, PSC_HANDOFF, PSC_ERROR,
    PSC_INIT, PSC_FINISHED
  } psc_state_t;
endpackage : psc_pkg

// ==== hdl/psc_fifo.sv ====
// Parameterised valid/ready FIFO for lane words
`timescale 1ns/1ps
`default_nettype none
module psc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             do_wr;
  logic             do_rd;

  // ==========================================================
  // Pointer and count update
  always_comb
  begin
    do_wr       = in_valid_i && (count != DEPTH[AW:0]);
    do_rd       = out_ready_i && (count != '0);
    next_wr_ptr = do_wr ? AW'((32'(wr_ptr) + 1) % DEPTH) : wr_ptr;
    next_rd_ptr = do_rd ? AW'((32'(rd_ptr) + 1) % DEPTH) : rd_ptr;
    next_count  = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage array
  always_ff @(posedge clk_i)
  begin
    if (do_wr)
      mem[wr_ptr] <= in_data_i;
  end

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
endmodule : psc_fifo
`default_nettype wire

// ==== hdl/psc_loader.sv ====
// Passive serial configuration memory: lane streaming, cascade, errors
// Summary of operation
// - Lane width is 1, 2, 4 or 8 serial data lines, one stream each.
// - Unused lanes carry no stream; their outputs stay idle low.
// - One lane may feed two daisy-chained targets; stream is just longer.
// - Identical-data targets share all lines and finish together.
// - Master memory drives configuration clock to targets and slaves.
// - Master select comes from done line; cascade out feeds next select.
// - After all data is sent, cascade output goes low selecting next.
// - Hand-off to next memory completes within one config clock.
// - Enhanced variant does not cascade; only the older variant does.
// - Any error stops loading chain-wide; chain reloads from start.
// - Done missing after data: output enable driven low, resets all.
// - Done and status lines are wired together across a mixed chain.
// - JTAG restart instruction pulses initiate-configuration pin low.
// - User mode follows done by 136, 40 or 10 init clocks per family.
// - Init clock is oscillator/user clock or config clock/user clock.
// - Targets latch bits on rising config clock until done goes high.
// - Wait 64 (enhanced) or 16 (older) clocks for done, else fail; only a master counts them, a slave waits without limit.
// - Status released after at most 40 us; memory then retries.
// - Finished daisy-chain target drives chain enable low for next.
`timescale 1ns/1ps
`default_nettype none
`include "psc_consts.svh"
module psc_loader #(
  parameter int LANES     = `PSC_LANES_DEF,
  parameter bit ENHANCED  = 1'b1,
  parameter bit MASTER    = 1'b1,
  parameter int CLKDIV    = `PSC_CLKDIV_DEF,
  parameter int RETRY_CYC = `PSC_RETRY_CYC
) (
  input  wire logic             CLK_SYS_I,
  input  wire logic             RST_I,
  input  wire logic [1:0]       FAMILY_I,
  input  wire logic             USE_USER_CLK_I,
  input  wire logic             JTAG_RESTART_I,
  input  wire logic             WORD_VALID_I,
  output logic                  WORD_READY_O,
  input  wire logic [LANES-1:0] WORD_DATA_I,
  input  wire logic             WORD_LAST_I,
  input  wire logic             CONFIG_CLOCK_I,
  input  wire logic             USER_INIT_CLOCK_I,
  input  wire logic             MEMORY_SELECT_N_I,
  input  wire logic             STATUS_I,
  input  wire logic             DONE_I,
  output logic                  CONFIG_CLOCK_O,
  output logic [LANES-1:0]      SERIAL_DATA_LANE_O,
  output logic                  CASCADE_OUT_N_O,
  output logic                  OE_O,
  output logic                  OE_OE_O,
  output logic                  INIT_CONF_N_O,
  output logic                  INIT_CONF_N_OE_O,
  output logic                  USER_MODE_O,
  output logic                  ERROR_O
);
  localparam int CW = 16;
  localparam logic [CW-1:0] HALF = CW'(CLKDIV / 2 - 1);

  // ==========================================================
  // Input synchronisers
  logic [4:0] s1;
  logic [4:0] s2;
  logic [4:0] s3;
  always_ff @(posedge CLK_SYS_I)
  begin
    s1 <= {CONFIG_CLOCK_I, USER_INIT_CLOCK_I, MEMORY_SELECT_N_I,
           STATUS_I, DONE_I};
    s2 <= s1;
    s3 <= s2;
  end
  wire logic sel_n   = s2[2];
  wire logic status  = s2[1];    // Wired-AND seen low if anyone pulls
  wire logic done    = s2[0];    // Shared done net
  wire logic ext_rise = s2[4] & ~s3[4];
  wire logic usr_rise = s2[3] & ~s3[3];

  // ==========================================================
  // Initialization cycle count per family
  function automatic logic [7:0] init_cycles(input logic [1:0] fam);
    case (fam)
      2'h0:    init_cycles = 8'(`PSC_INIT_FAM0);
      2'h1:    init_cycles = 8'(`PSC_INIT_FAM1);
      default: init_cycles = 8'(`PSC_INIT_FAM23);
    endcase
  endfunction : init_cycles

  // Config clock runs only while a frame, its tail or init is in progress
  function automatic logic clock_runs(input psc_pkg::psc_state_t s);
    clock_runs = (s == psc_pkg::PSC_SEND) || (s == psc_pkg::PSC_HANDOFF)
              || (s == psc_pkg::PSC_DONEWAIT) || (s == psc_pkg::PSC_INIT);
  endfunction : clock_runs

  // ==========================================================
  // Data FIFO
  logic             f_valid;
  logic             f_ready;
  logic [LANES:0]   f_data;
  logic             f_pop;
  psc_fifo #(.WIDTH(LANES + 1), .DEPTH(`PSC_FIFO_DEPTH)) u_fifo (
    .clk_i       (CLK_SYS_I),
    .rst_i       (RST_I),
    .in_valid_i  (WORD_VALID_I),
    .in_ready_o  (f_ready),
    .in_data_i   ({WORD_LAST_I, WORD_DATA_I}),
    .out_valid_o (f_valid),
    .out_ready_i (f_pop),
    .out_data_o  (f_data)
  );

  // ==========================================================
  // State registers and next values
  psc_pkg::psc_state_t state;
  psc_pkg::psc_state_t next_state;
  logic [CW-1:0]    div;
  logic [CW-1:0]    next_div;
  logic             cclk;
  logic             next_cclk;
  logic [CW-1:0]    cnt;
  logic [CW-1:0]    next_cnt;
  logic [LANES-1:0] lane;
  logic [LANES-1:0] next_lane;
  logic             casc_n;
  logic             next_casc_n;
  logic             oe_low;
  logic             next_oe_low;
  logic             init_low;
  logic             next_init_low;
  logic [4:0]       init_cnt;
  logic [4:0]       next_init_cnt;
  logic             umode;
  logic             next_umode;
  logic             err;
  logic             next_err;
  logic             was_last;
  logic             next_was_last;
  logic             tick_rise;
  logic             tick_fall;
  logic             init_tick;

  always_comb
  begin
    next_state    = state;
    next_div      = div;
    next_cclk     = cclk;
    next_cnt      = cnt;
    next_lane     = lane;
    next_casc_n   = casc_n;
    next_oe_low   = oe_low;
    next_init_low = init_low;
    next_init_cnt = init_cnt;
    next_umode    = umode;
    next_err      = err;
    next_was_last = was_last;
    f_pop         = 1'b0;
    // Master divides its own clock to make config clock
    tick_rise = 1'b0;
    tick_fall = 1'b0;
    if (MASTER)
    begin
      // Parked high inside, so a frame opens with a fall that loads data
      if (!clock_runs(state))
      begin
        next_div  = HALF;
        next_cclk = 1'b1;
      end
      else if (div == HALF)
      begin
        next_div  = '0;
        next_cclk = ~cclk;
        tick_rise = ~cclk;
        tick_fall = cclk;
      end
      else
        next_div = div + 1'b1;
    end
    else
    begin
      tick_rise = ext_rise;
      tick_fall = s3[4] & ~s2[4];
    end
    // Init clock: user clock, config clock (families 2 and 3) or every system clock
    init_tick = USE_USER_CLK_I ? usr_rise
              : (FAMILY_I[1] ? tick_rise : 1'b1);
    // JTAG restart pulses the initiate pin low
    if (JTAG_RESTART_I)
    begin
      next_init_low = 1'b1;
      next_init_cnt = 5'(`PSC_RESTART_PULSE);
    end
    else if (init_cnt != '0)
      next_init_cnt = init_cnt - 1'b1;
    else
      next_init_low = 1'b0;

    case (state)
      psc_pkg::PSC_IDLE:
      begin
        next_casc_n = 1'b1;
        next_lane   = '0;
        // Selected by done low (master) or previous cascade
        if (!sel_n && !done)
          next_state = psc_pkg::PSC_WAITREL;
      end
      psc_pkg::PSC_WAITREL:
        if (status)
          next_state = psc_pkg::PSC_SEND;
      psc_pkg::PSC_SEND:
      begin
        // Any low status stops the chain
        if (!status)
        begin
          next_state = psc_pkg::PSC_ERROR;
          next_err   = 1'b1;
        end
        // Data changes on falling edge; targets sample on rise
        else if (tick_fall && f_valid)
        begin
          next_lane     = f_data[LANES-1:0];
          f_pop         = 1'b1;
          next_was_last = f_data[LANES];
        end
        else if (tick_fall && was_last)
        begin
          next_cnt   = '0;
          next_state = (!ENHANCED && !MASTER) ? psc_pkg::PSC_HANDOFF
                     : (!ENHANCED ? psc_pkg::PSC_HANDOFF
                                  : psc_pkg::PSC_DONEWAIT);
          // Older variant hands off at once, no gap
          if (!ENHANCED)
            next_casc_n = 1'b0;
        end
      end
      psc_pkg::PSC_HANDOFF,
      psc_pkg::PSC_DONEWAIT:
      begin
        if (done)
        begin
          next_state = psc_pkg::PSC_INIT;
          next_cnt   = '0;
        end
        else if (!status)
        begin
          next_state = psc_pkg::PSC_ERROR;
          next_err   = 1'b1;
        end
        else if (MASTER && tick_rise)
        begin
          next_cnt = cnt + 1'b1;
          // Done must rise in 64 or 16 config clocks
          if (cnt == CW'((ENHANCED ? `PSC_WAIT_ENH : `PSC_WAIT_OLD) - 1))
          begin
            next_state  = psc_pkg::PSC_ERROR;
            next_err    = 1'b1;
            next_oe_low = 1'b1;
            next_cnt    = '0;
          end
        end
      end
      psc_pkg::PSC_ERROR:
      begin
        next_casc_n   = 1'b1;
        next_lane     = '0;
        next_was_last = 1'b0;
        next_cnt      = cnt + 1'b1;
        if (oe_low && cnt == CW'(`PSC_ERR_PULSE))
        begin
          next_oe_low = 1'b0;
          next_cnt    = '0;
        end
        // Retry once status released, bounded wait
        if (!oe_low && status)
        begin
          next_state = psc_pkg::PSC_IDLE;
          next_cnt   = '0;
        end
        else if (!oe_low && cnt == CW'(RETRY_CYC))
        begin
          next_oe_low = 1'b1;
          next_cnt    = '0;
        end
      end
      psc_pkg::PSC_INIT:
      begin
        // Count init clocks after done
        if (init_tick)
          next_cnt = cnt + 1'b1;
        if (cnt == CW'(init_cycles(FAMILY_I)))
        begin
          next_umode = 1'b1;
          next_state = psc_pkg::PSC_FINISHED;
        end
        if (!done)
          next_state = psc_pkg::PSC_ERROR;
      end
      psc_pkg::PSC_FINISHED:
        // Reconfiguration drops done and restarts
        if (!done)
        begin
          next_umode = 1'b0;
          next_casc_n = 1'b1;
          next_state = psc_pkg::PSC_IDLE;
        end
      default:
        next_state = psc_pkg::PSC_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      state    <= psc_pkg::PSC_IDLE;
      div      <= '0;
      cclk     <= 1'b0;
      cnt      <= '0;
      lane     <= '0;
      casc_n   <= 1'b1;
      oe_low   <= 1'b0;
      init_low <= 1'b0;
      init_cnt <= '0;
      umode    <= 1'b0;
      err      <= 1'b0;
      was_last <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      div      <= next_div;
      cclk     <= next_cclk;
      cnt      <= next_cnt;
      lane     <= next_lane;
      casc_n   <= next_casc_n;
      oe_low   <= next_oe_low;
      init_low <= next_init_low;
      init_cnt <= next_init_cnt;
      umode    <= next_umode;
      err      <= next_err;
      was_last <= next_was_last;
    end
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      CONFIG_CLOCK_O     <= 1'b0;
      SERIAL_DATA_LANE_O <= '0;
      CASCADE_OUT_N_O    <= 1'b1;
      OE_OE_O            <= 1'b0;
      INIT_CONF_N_OE_O   <= 1'b0;
      USER_MODE_O        <= 1'b0;
      ERROR_O            <= 1'b0;
      WORD_READY_O       <= 1'b0;
      OE_O               <= 1'b0;
      INIT_CONF_N_O      <= 1'b0;
    end
    else
    begin
      // No rising edge reaches the pin outside a frame, its tail or init
      CONFIG_CLOCK_O     <= MASTER ? (next_cclk & clock_runs(state)
                                      & clock_runs(next_state)) : 1'b0;
      SERIAL_DATA_LANE_O <= next_lane;
      CASCADE_OUT_N_O    <= next_casc_n;
      OE_OE_O            <= next_oe_low;
      INIT_CONF_N_OE_O   <= next_init_low;
      USER_MODE_O        <= next_umode;
      ERROR_O            <= next_err;
      WORD_READY_O       <= f_ready;
      OE_O               <= 1'b0;     // Open drain: only ever pulls low
      INIT_CONF_N_O      <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions and covers
  oe_on_timeout_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    $rose(oe_low) |-> state == psc_pkg::PSC_ERROR)
    else $error("oe low without error");
  casc_after_data_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    $fell(casc_n) |-> !ENHANCED && $past(was_last))
    else $error("cascade out fell early");
  enh_no_casc_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    ENHANCED |-> casc_n)
    else $error("enhanced variant cascaded");
  stop_on_err_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    state == psc_pkg::PSC_SEND && !status |=> state == psc_pkg::PSC_ERROR)
    else $error("error did not stop load");
  restart_pulse_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    JTAG_RESTART_I |=> init_low [*8])
    else $error("restart pulse too short");
  data_on_fall_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    f_pop |-> tick_fall && state == psc_pkg::PSC_SEND)
    else $error("data changed off falling edge");
  umode_after_init_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    $rose(umode) |-> $past(state) == psc_pkg::PSC_INIT)
    else $error("user mode without init");
  clk_div_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    MASTER && tick_rise |=> cclk)
    else $error("config clock not driven");
  clk_idle_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !clock_runs(state) |=> !CONFIG_CLOCK_O)
    else $error("config clock ran outside a frame");
  send_c: cover property (@(posedge CLK_SYS_I) f_pop);
  umode_c: cover property (@(posedge CLK_SYS_I) $rose(umode));
  err_c: cover property (@(posedge CLK_SYS_I) $rose(oe_low));
endmodule : psc_loader
`default_nettype wire

// ==== dv/psc_target.sv ====
// Behavioural target chain as seen from the loader's pins
`timescale 1ns/1ps
`default_nettype none
module psc_target #(
  parameter int LANES = 4
) (
  input  wire logic             clk_i,
  input  wire logic             cfg_clk_i,
  input  wire logic [LANES-1:0] data_i,
  input  wire logic             oe_pull_i,
  input  wire logic             init_pull_i,
  input  wire logic             hold_i,
  input  wire logic             fail_i,
  input  wire logic [7:0]       words_i,
  output logic                  status_o,
  output logic                  done_o,
  output int                    cap_cnt_o,
  output logic [LANES-1:0]      cap_data_o
);
  logic done_low = 1'b1;
  logic cfg_q    = 1'b0;
  int   tmr      = 0;
  // ======
  // Wired-AND lines: any low driver wins, pull-up otherwise
  assign status_o = !(hold_i || tmr != 0 || oe_pull_i);
  assign done_o   = !done_low;
  // One process: reset on restart pin or forced status, time-out, then
  // a bit latched at each config clock rise; a failing target keeps done
  always @(posedge clk_i)
  begin
    cfg_q <= cfg_clk_i;
    if (hold_i || oe_pull_i || init_pull_i)
    begin
      done_low  <= 1'b1;
      cap_cnt_o <= 0;
      tmr       <= 30;
    end
    else if (tmr != 0)
      tmr <= tmr - 1;
    else if (cfg_clk_i && !cfg_q && done_low && cap_cnt_o < int'(words_i))
    begin
      cap_data_o <= data_i;
      cap_cnt_o  <= cap_cnt_o + 1;
      if (cap_cnt_o + 1 == int'(words_i) && !fail_i)
        done_low <= 1'b0;
    end
  end
endmodule : psc_target
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the passive serial loader
`timescale 1ns/1ps
`default_nettype none
`include "psc_consts.svh"
module testbench;
  localparam int LANES = 4;   // Four lanes suit three or four targets
  localparam int DIV   = 8;
  localparam int NW    = 12;
  logic             clk      = 1'b0;
  logic             rst      = 1'b1;
  logic             lclk     = 1'b0;
  logic             lclk_en  = 1'b0;
  logic [1:0]       fam      = 2'h0;
  logic             use_uclk = 1'b0;
  logic             jtag     = 1'b0;
  logic             wvalid   = 1'b0;
  logic [LANES-1:0] wdata    = 4'h0;
  logic             wlast    = 1'b0;
  logic             hold     = 1'b1;
  logic             fail     = 1'b0;
  logic             wready, cclk, casc_n, oe, oe_oe, init_n, init_oe;
  logic             umode, err, status, done;
  logic [LANES-1:0] lane, cap_data;
  int               cap_cnt;
  int               err_count = 0;
  int               cmp_count = 0;
  int               cyc       = 0;
  logic [LANES-1:0] exp_q[$];
  // ======
  // System clock and a link clock that stands still low while lclk_en is low (during reset)
  initial forever #5 clk = ~clk;
  initial
  begin
    #3;
    forever #62.5 lclk = lclk_en & ~lclk;
  end
  psc_loader #(.LANES(LANES), .CLKDIV(DIV), .RETRY_CYC(50)) DUT (
    .CLK_SYS_I(clk), .RST_I(rst), .FAMILY_I(fam),
    .USE_USER_CLK_I(use_uclk), .JTAG_RESTART_I(jtag),
    .WORD_VALID_I(wvalid), .WORD_READY_O(wready), .WORD_DATA_I(wdata),
    .WORD_LAST_I(wlast), .CONFIG_CLOCK_I(lclk), .USER_INIT_CLOCK_I(lclk),
    .MEMORY_SELECT_N_I(done), .STATUS_I(status), .DONE_I(done),
    .CONFIG_CLOCK_O(cclk), .SERIAL_DATA_LANE_O(lane),
    .CASCADE_OUT_N_O(casc_n), .OE_O(oe), .OE_OE_O(oe_oe),
    .INIT_CONF_N_O(init_n), .INIT_CONF_N_OE_O(init_oe),
    .USER_MODE_O(umode), .ERROR_O(err));
  // Done line also selects the master memory
  psc_target #(.LANES(LANES)) tgt (
    .clk_i(clk), .cfg_clk_i(cclk), .data_i(lane), .oe_pull_i(oe_oe),
    .init_pull_i(init_oe), .hold_i(hold), .fail_i(fail),
    .words_i(8'h0C), .status_o(status), .done_o(done),
    .cap_cnt_o(cap_cnt), .cap_data_o(cap_data));
  // ======
  // Comparison and closing report
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s exp %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  // Each bit latched by the target is matched to the oldest word sent
  always @(cap_cnt)
  begin
    #1;
    if (cap_cnt != 0)
    begin
      if (exp_q.size() == 0)
        chk("extra word", 1, 0);
      else
        chk("lane word", cap_data, exp_q.pop_front());
    end
  end
  // ======
  // Drivers: reset, word push, whole load
  task automatic do_reset();
    @(negedge clk);
    rst     = 1'b1;
    hold    = 1'b1;
    lclk_en = 1'b0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask : do_reset
  task automatic push(input logic last);
    int k;
    k = 0;
    while (wready !== 1'b1 && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    wvalid = 1'b1;
    wdata  = LANES'($urandom);
    wlast  = last;
    @(negedge clk);
    exp_q.push_back(wdata);
    wvalid = 1'b0;
    @(negedge clk);
  endtask : push
  task automatic wait_hi(ref logic s, input int lim);
    int k;
    k = 0;
    while (s !== 1'b1 && k < lim)
    begin
      @(negedge clk);
      k++;
    end
  endtask : wait_hi
  task automatic load(input logic [1:0] f, input logic u, input logic bad);
    int ni;
    int lo;
    int hi;
    int t;
    do_reset();
    fam      = f;
    use_uclk = u;
    fail     = bad;
    lclk_en  = 1'b1;
    ni = f == 0 ? `PSC_INIT_FAM0 : f == 1 ? `PSC_INIT_FAM1 : `PSC_INIT_FAM23;
    // Target still in reset: the buffer fills and then refuses
    for (int i = 0; i < `PSC_FIFO_DEPTH; i++) push(1'b0);
    repeat (2) @(negedge clk);
    chk("ready when full", wready, 0);
    hold = 1'b0;
    for (int i = `PSC_FIFO_DEPTH; i < NW; i++) push(i == NW - 1);
    t = 0;
    while (cap_cnt != NW && t < 3000)
    begin
      @(negedge clk);
      t++;
    end
    t = 0;
    while (done !== 1'b1 && oe_oe !== 1'b1 && t < 3000)
    begin
      @(negedge clk);
      t++;
    end
    chk("words left", exp_q.size(), 0);
    if (!bad)
    begin
      // User clock about 12.5 cycles, config clock DIV, oscillator 1 cycle
      lo = u ? (ni - 1) * 12 : f > 1 ? (ni - 1) * DIV : ni;
      hi = u ? ni * 13 + 8 : f > 1 ? ni * DIV + 8 : ni + 8;
      t = 0;
      while (umode !== 1'b1 && t < 3000)
      begin
        @(negedge clk);
        t++;
      end
      chk("init cycles", t >= lo && t <= hi, 1);
      chk("cascade idle", casc_n, 1);
      chk("error flag", err, 0);
    end
    else
    begin
      chk("done wait", t >= 63 * DIV && t <= 66 * DIV, 1);
      chk("oe level", oe, 0);
      t = 0;
      while (oe_oe === 1'b1 && t < 100)
      begin
        @(negedge clk);
        t++;
      end
      chk("oe pulse", t, `PSC_ERR_PULSE + 1);
      chk("error flag", err, 1);
      chk("user mode", umode, 0);
    end
  endtask : load
  // ======
  // Main sequence
  initial
  begin
    int t;
    void'($urandom(3));
    for (int f = 0; f < 4; f++)
      load(f[1:0], f == 3, 1'b0);
    // Restart instruction pulses the initiate pin low
    jtag = 1'b1;
    @(negedge clk);
    jtag = 1'b0;
    wait_hi(init_oe, 20);
    chk("restart level", init_n, 0);
    t = 0;
    while (init_oe === 1'b1 && t < 100)
    begin
      @(negedge clk);
      t++;
    end
    chk("restart pulse", t, `PSC_RESTART_PULSE + 1);
    chk("done after restart", done, 0);
    load(2'h0, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
